// File: design/tbid_core.sv
// Decode and execute core for the 13-bit instruction subset, AXI4-Lite
//
// Functional notes
// - Accept 13-bit words, opcode plus operands
// - Default instruction takes one two-clock cycle
// - Program counter writes take two cycles
// - Option bit 10 picks two or four clocks
// - Any register bit settable, clearable, testable; code sets and clears only, tests decode as illegal
// - I/O registers addressed like ordinary registers
// - Extract register, bit and literal fields
// - Zero word is no-op, flags other than osc_stopped unchanged
// - Decimal adjust accumulator, borrow flag only
// - Move accumulator to/from control register
// - Sleep clears watchdog, stops oscillator, flags
// - Watchdog clear clears watchdog, updates flags
// - Move accumulator to/from I/O control registers
// - Enable or disable interrupts globally
// - Return loads PC; interrupt return enables
// - Store accumulator into addressed register
// - Clear accumulator or register, update zero
// - Register minus accumulator, three flags
// - Decrement register into accumulator or register
// - OR accumulator with register, zero flag
// - AND accumulator with register, zero flag
// - XOR accumulator with register, zero flag
// - I/O control selections 5,6,B-F only
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tbid_core
    import tbid_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic osc_stop,
    output logic int_enable,
    output logic wdt_clear,
    output logic instr_done
);
    // ************************************************************
    // State
    // ************************************************************
    tbid_state_e st_r;
    tbid_flags_s flags_r, flags_nxt;
    logic [12:0] ir_r, option_r;
    logic [7:0] acc_r, acc_nxt, ctl_r, ctl_nxt, regsel_r;
    logic [11:0] pc_r, pc_nxt, stack_r;
    logic [7:0] regfile [64];
    logic [7:0] ioc [16];
    logic [2:0] cpc_r, phase_r;
    logic [1:0] cnt_r;
    logic illegal_r, illegal_nxt, wdt_clear_r, done_r;
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;

    // ************************************************************
    // Field extraction and decode
    // ************************************************************
    wire [5:0] rsel = ir_r[5:0];
    wire [2:0] bsel = ir_r[8:6];
    wire [3:0] isel = ir_r[3:0];
    wire [4:0] alu_op = ir_r[11:7];
    wire dest_reg = ir_r[6];
    wire pc_sel = ({2'b00, rsel} == REG_PC_IDX);
    // I/O registers read through the same port as general ones
    wire [7:0] rval = pc_sel ? pc_r[7:0] : regfile[rsel];
    wire is_nop = (ir_r == 13'h0000);
    wire is_daa = (ir_r == 13'h0001);
    wire is_ctlw = (ir_r == 13'h0002);
    wire is_sleep = (ir_r == 13'h0003);
    wire is_watchdog_clear_op = (ir_r == 13'h0004);
    wire is_eni = (ir_r == 13'h0010);
    wire is_interrupt_mask_op = (ir_r == 13'h0011);
    wire is_ret = (ir_r == 13'h0012);
    wire is_interrupt_return_op = (ir_r == 13'h0013);
    wire is_ctlr = (ir_r == 13'h0014);
    // Fixed codes shadow the I/O patterns sharing upper bits
    wire fix_lo = (ir_r[12:4] == 9'h000) && (isel <= 4'h4);
    wire fix_hi = (ir_r[12:4] == 9'h001) && (isel <= 4'h4);
    wire ioc_ok = (isel == 4'h5) || (isel == 4'h6) || (isel >= 4'hB);
    wire is_iow = (ir_r[12:4] == 9'h000) && !fix_lo;
    wire is_ior = (ir_r[12:4] == 9'h001) && !fix_hi;
    wire is_mov = (ir_r[12:6] == 7'h01);
    wire is_zero_accumulator_op = (ir_r == 13'h0080);
    wire is_clr = (ir_r[12:6] == 7'h03);
    wire is_alu = (ir_r[12] == 1'b0) && (alu_op >= 5'h02) && (alu_op <= 5'h06);
    // Set and clear only; skip-on-bit tests fall to illegal
    wire is_bit = (ir_r[12:10] == 3'b010);
    wire reg_wr = is_mov || is_clr || (is_alu && dest_reg) || is_bit;
    wire two_cyc = (reg_wr && pc_sel) || is_ret || is_interrupt_return_op;
    wire [1:0] need = two_cyc ? CYC_PC_WRITE : CYC_NORMAL;
    wire cyc_tick = (phase_r == cpc_r - 3'h1);
    wire done = (st_r == ST_EXEC) && cyc_tick && (cnt_r == need - 2'h1);

    // ************************************************************
    // Execute
    // ************************************************************
    logic [7:0] res, wval;
    logic [8:0] diff, adj;
    logic wr_acc, wr_reg, lo_adj, hi_adj;
    always_comb begin
        res = 8'h00;
        wval = 8'h00;
        wr_acc = 1'b0;
        wr_reg = 1'b0;
        diff = {1'b0, rval} - {1'b0, acc_r};
        lo_adj = (acc_r[3:0] > 4'h9);
        hi_adj = (acc_r > 8'h99) || flags_r.borrow_out;
        adj = {1'b0, acc_r} + (lo_adj ? 9'h006 : 9'h000)
            + (hi_adj ? 9'h060 : 9'h000);
        acc_nxt = acc_r;
        ctl_nxt = ctl_r;
        flags_nxt = flags_r;
        flags_nxt.osc_stopped = 1'b0;
        pc_nxt = pc_r + 12'h001;
        illegal_nxt = 1'b0;
        if (is_nop) begin
        end else if (is_daa) begin
            acc_nxt = adj[7:0];
            flags_nxt.borrow_out = hi_adj;
        end else if (is_ctlw) begin
            ctl_nxt = acc_r;
        end else if (is_ctlr) begin
            acc_nxt = ctl_r;
        end else if (is_sleep || is_watchdog_clear_op) begin
            flags_nxt.wd_expired = 1'b1;
            flags_nxt.low_energy = is_watchdog_clear_op;
            flags_nxt.osc_stopped = is_sleep;
        end else if (is_eni || is_interrupt_mask_op) begin
            flags_nxt.int_en = is_eni;
        end else if (is_ret || is_interrupt_return_op) begin
            pc_nxt = stack_r;
            if (is_interrupt_return_op) begin
                flags_nxt.int_en = 1'b1;
            end
        end else if (is_iow || is_ior) begin
            if (!ioc_ok) begin
                illegal_nxt = 1'b1;
            end else if (is_ior) begin
                acc_nxt = ioc[isel];
            end
        end else if (is_mov) begin
            wval = acc_r;
        end else if (is_zero_accumulator_op || is_clr) begin
            acc_nxt = 8'h00;
            flags_nxt.result_null = 1'b1;
        end else if (is_alu) begin
            case (alu_op)
                5'h02: begin
                    res = diff[7:0];
                    flags_nxt.borrow_out = diff[8];
                    flags_nxt.half_borrow = rval[3:0] < acc_r[3:0];
                end
                5'h03: res = rval - 8'h01;
                5'h04: res = acc_r | rval;
                5'h05: res = acc_r & rval;
                default: res = acc_r ^ rval;
            endcase
            flags_nxt.result_null = (res == 8'h00);
            wr_acc = !dest_reg;
            wval = res;
        end else if (is_bit) begin
            wval = rval;
            wval[bsel] = ir_r[9];
        end else begin
            illegal_nxt = 1'b1;
        end
        if (is_clr) begin
            acc_nxt = acc_r;
        end
        if (wr_acc) begin
            acc_nxt = res;
        end
        wr_reg = reg_wr;
        if (wr_reg && pc_sel) begin
            pc_nxt = {pc_r[11:8], wval};
        end
    end

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    function automatic logic [32:0] reg_read(input logic [ADDR_W-1:0] a);
        logic [7:0] o;
        o = a[7:0];
        if (o == OFF_INSTR) reg_read = {1'b1, 19'h0, ir_r};
        else if (o == OFF_OPTION) reg_read = {1'b1, 19'h0, option_r};
        else if (o == OFF_ACC) reg_read = {1'b1, 24'h0, acc_r};
        else if (o == OFF_STATUS) reg_read = {1'b1, 23'h0, illegal_r,
            flags_r, st_r == ST_EXEC};
        else if (o == OFF_CTL) reg_read = {1'b1, 24'h0, ctl_r};
        else if (o == OFF_PC) reg_read = {1'b1, 20'h0, pc_r};
        else if (o == OFF_REGSEL) reg_read = {1'b1, 24'h0, regsel_r};
        else if (o == OFF_REGDATA) reg_read = {1'b1, 24'h0,
            (regsel_r == REG_PC_IDX) ? pc_r[7:0] : regfile[regsel_r[5:0]]};
        else if (o == OFF_IOCDATA) reg_read = {1'b1, 24'h0,
            ioc[regsel_r[3:0]]};
        else if (o == OFF_STACK) reg_read = {1'b1, 20'h0, stack_r};
        else reg_read = 33'h0;
    endfunction

    // Procedural so state read inside the function wakes it up
    logic [32:0] wr_cur, rd_cur;
    always_comb begin
        wr_cur = reg_read(awaddr_r);
        rd_cur = reg_read(s_axi_araddr);
    end
    wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
        {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire [31:0] wm = (wr_cur[31:0] & ~wmask) | (wdata_r & wmask);
    wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
    // Writes land only while idle so software never races a commit
    wire sw_wr = wr_fire && wr_cur[32] && (st_r == ST_IDLE);
    wire [7:0] wo = awaddr_r[7:0];
    wire start = sw_wr && (wo == OFF_INSTR) && (wstrb_r[1:0] != 2'b00);
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bresp_r <= RESP_OKAY;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_cur[32] ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_cur[31:0];
                rresp_r <= rd_cur[32] ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Sequencer and architectural state
    // ************************************************************
    wire rf_we = (done && wr_reg && !pc_sel)
        || (sw_wr && wo == OFF_REGDATA && regsel_r != REG_PC_IDX);
    wire [5:0] rf_idx = done ? rsel : regsel_r[5:0];
    wire [7:0] rf_d = done ? wval : wm[7:0];
    wire ioc_we = (done && is_iow && ioc_ok)
        || (sw_wr && wo == OFF_IOCDATA);
    wire [3:0] ioc_idx = done ? isel : regsel_r[3:0];
    wire [7:0] ioc_d = done ? acc_r : wm[7:0];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= ST_IDLE;
            ir_r <= 13'h0000;
            option_r <= OPTION_RST;
            cpc_r <= CLKS_FAST;
            phase_r <= 3'h0;
            cnt_r <= 2'h0;
            acc_r <= 8'h00;
            ctl_r <= 8'h00;
            pc_r <= 12'h000;
            stack_r <= 12'h000;
            regsel_r <= 8'h00;
            flags_r <= '0;
            illegal_r <= 1'b0;
            wdt_clear_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            wdt_clear_r <= done && (is_sleep || is_watchdog_clear_op);
            done_r <= done;
            if (start) begin
                st_r <= ST_EXEC;
                ir_r <= wm[12:0];
                cpc_r <= option_r[OPT_CLKS_BIT] ? CLKS_SLOW : CLKS_FAST;
                phase_r <= 3'h0;
                cnt_r <= 2'h0;
            end else if (st_r == ST_EXEC) begin
                phase_r <= cyc_tick ? 3'h0 : phase_r + 3'h1;
                cnt_r <= cyc_tick ? cnt_r + 2'h1 : cnt_r;
                if (done) begin
                    st_r <= ST_IDLE;
                    acc_r <= acc_nxt;
                    ctl_r <= ctl_nxt;
                    flags_r <= flags_nxt;
                    pc_r <= pc_nxt;
                    illegal_r <= illegal_nxt;
                end
            end
            if (sw_wr && wo == OFF_OPTION) option_r <= wm[12:0];
            if (sw_wr && wo == OFF_ACC) acc_r <= wm[7:0];
            if (sw_wr && wo == OFF_CTL) ctl_r <= wm[7:0];
            if (sw_wr && wo == OFF_REGSEL) regsel_r <= wm[7:0];
            if (sw_wr && wo == OFF_STACK) stack_r <= wm[11:0];
            if (sw_wr && wo == OFF_STATUS) flags_r <= wm[7:1];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 64; i++) regfile[i] <= 8'h00;
            for (int j = 0; j < 16; j++) ioc[j] <= 8'h00;
        end else begin
            if (rf_we) regfile[rf_idx] <= rf_d;
            if (ioc_we) ioc[ioc_idx] <= ioc_d;
        end
    end

    assign osc_stop = flags_r.osc_stopped;
    assign int_enable = flags_r.int_en;
    assign wdt_clear = wdt_clear_r;
    assign instr_done = done_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    wire first_clk = (st_r == ST_EXEC) && (phase_r == 3'h0) && (cnt_r == 2'h0);
    sequence s_fast_single;
        first_clk && (cpc_r == CLKS_FAST) && !two_cyc;
    endsequence
    sequence s_slow_double;
        first_clk && (cpc_r == CLKS_SLOW) && two_cyc;
    endsequence
    fast_cycle_a: assert property (@(posedge clk) disable iff (!nrst)
        s_fast_single |-> !done ##1 done)
        else $error("fast instruction not done in two clocks");
    slow_double_a: assert property (@(posedge clk) disable iff (!nrst)
        s_slow_double |-> !done [*7] ##1 done)
        else $error("slow pc write not done in eight clocks");
    nop_flags_a: assert property (@(posedge clk) disable iff (!nrst)
        done && is_nop |=> flags_r[5:0] == $past(flags_r[5:0]))
        else $error("no-op changed flags");
    ctl_write_a: assert property (@(posedge clk) disable iff (!nrst)
        done && is_ctlw |=> ctl_r == $past(acc_r))
        else $error("control register not loaded");
    sleep_flags_a: assert property (@(posedge clk) disable iff (!nrst)
        done && is_sleep |=> osc_stop && wdt_clear && !flags_r.low_energy)
        else $error("sleep effects missing");
    ioc_invalid_a: assert property (@(posedge clk) disable iff (!nrst)
        done && is_ior && !ioc_ok |=> illegal_r && acc_r == $past(acc_r))
        else $error("invalid io selection executed");
    sub_acc_a: assert property (@(posedge clk) disable iff (!nrst)
        done && is_alu && alu_op == 5'h02 && !dest_reg
        |=> acc_r == $past(diff[7:0]) && flags_r.borrow_out == $past(diff[8]))
        else $error("subtract result wrong");
    dec_acc_a: assert property (@(posedge clk) disable iff (!nrst)
        done && is_alu && alu_op == 5'h03 && !dest_reg
        |=> acc_r == $past(rval) - 8'h01)
        else $error("decrement result wrong");
    int_enable_a: assert property (@(posedge clk) disable iff (!nrst)
        done && (is_eni || is_interrupt_mask_op) |=> int_enable == $past(is_eni))
        else $error("interrupt enable not updated");
endmodule // tbid_core
`default_nettype wire

// File: design/tbid_pkg.sv
// Package: constants and types for the 13-bit instruction decoder
package tbid_pkg;
    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_OPTION = 8'h04;
    localparam logic [7:0] OFF_ACC = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_CTL = 8'h10;
    localparam logic [7:0] OFF_PC = 8'h14;
    localparam logic [7:0] OFF_REGSEL = 8'h18;
    localparam logic [7:0] OFF_REGDATA = 8'h1C;
    localparam logic [7:0] OFF_IOCDATA = 8'h20;
    localparam logic [7:0] OFF_STACK = 8'h24;
    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int OPT_CLKS_BIT = 10;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ILLEGAL_BIT = 8;
    localparam logic [12:0] OPTION_RST = 13'h0000;
    localparam logic [7:0] REG_PC_IDX = 8'h02;
    // ************************************************************
    // Timing: oscillator clocks per cycle, cycles per PC write
    // ************************************************************
    localparam logic [2:0] CLKS_FAST = 3'h2;
    localparam logic [2:0] CLKS_SLOW = 3'h4;
    localparam logic [1:0] CYC_NORMAL = 2'h1;
    localparam logic [1:0] CYC_PC_WRITE = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic osc_stopped;
        logic int_en;
        logic wd_expired;
        logic low_energy;
        logic result_null;
        logic half_borrow;
        logic borrow_out;
    } tbid_flags_s;
    typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} tbid_state_e;
endpackage

// File: tb/tbid_prog_mem.sv
// Program memory model holding the I/O control move words
`timescale 1ns/10ps
`default_nettype none
module tbid_prog_mem
    import tbid_pkg::*;
(
    input wire logic [5:0] addr,
    output logic [12:0] word
);
    // ************************************************************
    // Fetch
    // ************************************************************
    // Word at address s is the write move for selection s
    assign word = {7'h00, addr};
endmodule // tbid_prog_mem
`default_nettype wire

// File: tb/thirteen_bit_instruction_decode_tb.sv
// Self-checking bench for the instruction decode core
`timescale 1ns/10ps
`default_nettype none
module thirteen_bit_instruction_decode_tb
    import tbid_pkg::*;
;
    // ************************************************************
    // Signals
    // ************************************************************
    logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, osc_stop;
    logic int_enable, wdt_clear, instr_done, wd_seen, vld;
    logic [7:0] s_axi_awaddr, s_axi_araddr, a, r, g, res;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] pm_addr;
    logic [12:0] pm_word;
    logic [33:0] exp_q[$];
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int n, op;
    tbid_flags_s fl;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    tbid_core #(.ADDR_W(8)) i_tbid_core (
        .clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .osc_stop, .int_enable,
        .wdt_clear, .instr_done
    );
    tbid_prog_mem i_tbid_prog_mem (.addr(pm_addr), .word(pm_word));
    // ************************************************************
    // Tasks and response watcher
    // ************************************************************
    task automatic chk(input string nm, input logic [33:0] got,
                       input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Generous ceiling; a full run needs well under two thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 40000) begin
            error_cnt++;
            complete_run();
        end
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            if (exp_q.size() == 0) begin
                chk("unexpected", 34'h1, 34'h0);
            end else begin
                chk("resp", s_axi_bvalid ? {s_axi_bresp, 32'h0} :
                    {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
            end
        end
    end
    task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                      input logic [1:0] rs = RESP_OKAY,
                      input logic [3:0] st = 4'hF);
        @(posedge clk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        exp_q.push_back({rs, 32'h0});
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] d,
                      input logic [1:0] rs = RESP_OKAY);
        @(posedge clk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        exp_q.push_back({rs, d});
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask
    // Counts edges from the write answer to the done pulse
    task automatic ex(input logic [12:0] w, input int cy);
        wr(OFF_INSTR, {19'h0, w});
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (instr_done !== 1'b1 && n < 64);
        wd_seen = wdt_clear;
        chk("cycles", 34'(n), 34'(cy));
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        nrst = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        pm_addr = 6'h00;
        void'($urandom(4106));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(OFF_STATUS, 32'h0);
        wr(8'h80, 32'h1, RESP_SLVERR);
        rd(8'h80, 32'h0, RESP_SLVERR);
        wr(OFF_STATUS, 32'h2A);
        ex(13'h0000, 2);
        rd(OFF_STATUS, 32'h2A);
        for (int i = 0; i < 2; i++) begin
            wr(OFF_STATUS, 32'h0);
            wr(OFF_ACC, i ? 32'hA0 : 32'h0A);
            ex(13'h0001, 2);
            rd(OFF_ACC, i ? 32'h0 : 32'h10);
            rd(OFF_STATUS, {30'h0, i[0], 1'b0});
        end
        wr(OFF_ACC, 32'h5A);
        ex(13'h0002, 2);
        rd(OFF_CTL, 32'h5A);
        wr(OFF_ACC, 32'h0);
        ex(13'h0014, 2);
        rd(OFF_ACC, 32'h5A);
        for (int s = 5; s < 16; s++) begin
            vld = (s < 7) || (s > 10);
            pm_addr = 6'(s);
            g = 8'($urandom);
            wr(OFF_STATUS, 32'h0);
            wr(OFF_ACC, {24'h0, g});
            ex(pm_word, 2);
            rd(OFF_STATUS, vld ? 32'h0 : 32'h100);
            wr(OFF_REGSEL, 32'(s));
            rd(OFF_IOCDATA, vld ? {24'h0, g} : 32'h0);
            wr(OFF_ACC, 32'h0);
            ex(pm_word | 13'h0010, 2);
            rd(OFF_ACC, vld ? {24'h0, g} : 32'h0);
            rd(OFF_STATUS, vld ? 32'h0 : 32'h100);
        end
        wr(OFF_STATUS, 32'h0);
        ex(13'h0003, 2);
        chk("osc_stop", {33'h0, osc_stop}, 34'h1);
        chk("wdt_clear", {33'h0, wd_seen}, 34'h1);
        ex(13'h0004, 2);
        chk("osc_stop", {33'h0, osc_stop}, 34'h0);
        chk("wdt_clear", {33'h0, wd_seen}, 34'h1);
        rd(OFF_STATUS, 32'h30);
        ex(13'h0010, 2);
        chk("int_en", {33'h0, int_enable}, 34'h1);
        ex(13'h0011, 2);
        chk("int_en", {33'h0, int_enable}, 34'h0);
        wr(OFF_STACK, 32'h123);
        ex(13'h0013, 4);
        chk("int_en", {33'h0, int_enable}, 34'h1);
        rd(OFF_PC, 32'h123);
        wr(OFF_STACK, 32'h45);
        ex(13'h0011, 2);
        ex(13'h0012, 4);
        rd(OFF_PC, 32'h45);
        wr(OFF_ACC, 32'h40);
        ex(13'h0042, 4);
        rd(OFF_PC, 32'h40);
        wr(OFF_OPTION, 32'h400);
        ex(13'h0000, 4);
        ex(13'h0042, 8);
        wr(OFF_OPTION, 32'h0);
        // Passes with k bit 1 set use equal operands, zeroing subtract and XOR results
        for (int k = 0; k < 20; k++) begin
            op = k / 4;
            a = 8'($urandom);
            r = 8'h20 + 8'($urandom_range(31));
            g = k[1] ? a : 8'($urandom);
            case (op)
                0: res = g - a;
                1: res = g - 8'h01;
                2: res = a | g;
                3: res = a & g;
                default: res = a ^ g;
            endcase
            fl = '0;
            fl.result_null = (res == 8'h00);
            if (op == 0) begin
                fl.borrow_out = g < a;
                fl.half_borrow = g[3:0] < a[3:0];
            end
            wr(OFF_STATUS, 32'h0);
            wr(OFF_ACC, {24'h0, a});
            wr(OFF_REGSEL, {24'h0, r});
            wr(OFF_REGDATA, {24'h0, g});
            ex(13'h100 + 13'(op) * 13'h80 + 13'(k % 2) * 13'h40 + 13'(r), 2);
            rd(OFF_ACC, {24'h0, k[0] ? a : res});
            rd(OFF_REGDATA, {24'h0, k[0] ? res : g});
            rd(OFF_STATUS, {24'h0, fl, 1'b0});
        end
        wr(OFF_STATUS, 32'h0);
        wr(OFF_ACC, 32'h96);
        // Low byte not strobed, so the accumulator keeps its value
        wr(OFF_ACC, 32'h11, RESP_OKAY, 4'hE);
        rd(OFF_ACC, 32'h96);
        wr(OFF_REGSEL, 32'h21);
        ex(13'h0061, 2);
        rd(OFF_REGDATA, 32'h96);
        ex(13'h0A21, 2);
        rd(OFF_REGDATA, 32'h97);
        ex(13'h09E1, 2);
        rd(OFF_REGDATA, 32'h17);
        ex(13'h00E1, 2);
        rd(OFF_REGDATA, 32'h0);
        ex(13'h0080, 2);
        rd(OFF_ACC, 32'h0);
        rd(OFF_STATUS, 32'h8);
        complete_run();
    end
endmodule // thirteen_bit_instruction_decode_tb
`default_nettype wire
